// ---- fcsf_pkg.sv ----
// package of constants for the flash command status flag block
`default_nettype none
package fcsf_pkg;
    localparam logic [8:0] STATUS_OFFSET = 9'h105;
    localparam logic [8:0] CONFIG_OFFSET = 9'h103;
    localparam int BIT_CBE = 7;
    localparam int BIT_CC = 6;
    localparam int BIT_PV = 5;
    localparam int BIT_AE = 4;
    localparam int BIT_BLANK = 2;
    localparam int BIT_FAIL = 1;
    localparam int BIT_CBE_IE = 7;
    localparam int BIT_CC_IE = 6;
    localparam logic [7:0] STATUS_RESET = 8'hC0;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] CONFIG_MASK = 8'hC0;
    localparam logic [6:0] CMD_ERASE_VERIFY = 7'h05;
    localparam logic [6:0] CMD_PROGRAM = 7'h20;
    localparam logic [6:0] CMD_BURST = 7'h25;
    localparam logic [6:0] CMD_SECTOR_ERASE = 7'h40;
    localparam logic [6:0] CMD_MASS_ERASE = 7'h41;
endpackage
`default_nettype wire

// ---- fcsf_flags.sv ----
// status flag logic of the flash command controller
`default_nettype none
module fcsf_flags (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic special_mode,
    input wire logic [8:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic array_wr,
    input wire logic array_wr_aligned,
    input wire logic array_wr_protected,
    input wire logic cmd_wr,
    input wire logic [6:0] cmd_code,
    input wire logic seq_violation,
    input wire logic stop_req,
    input wire logic engine_done,
    input wire logic verify_blank,
    output logic launch,
    output logic [6:0] launch_cmd,
    output logic buffer_busy,
    output logic irq_buffer_empty,
    output logic irq_complete
);
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_ADDR, SEQ_CMD} fcsf_seq_e;

    fcsf_seq_e seq_q;
    fcsf_seq_e seq_d;
    logic cbe_q;
    logic cbe_d;
    logic cc_q;
    logic cc_d;
    logic pv_q;
    logic pv_d;
    logic ae_q;
    logic ae_d;
    logic blank_q;
    logic blank_d;
    logic fail_q;
    logic fail_d;
    logic [7:0] cfg_q;
    logic [7:0] cfg_d;
    logic [7:0] rdata_d;
    logic [6:0] cmd_q;
    logic [6:0] cmd_d;
    logic [6:0] active_cmd_q;
    logic [6:0] active_cmd_d;
    logic pending_q;
    logic pending_d;
    logic active_q;
    logic active_d;
    logic st_wr;
    logic st_one;
    logic blocked;
    logic do_launch;
    logic abort;
    logic bad_cmd;
    logic finish;
    logic chain;
    logic ae_set;
    logic pv_set;
    logic ev_done;
    logic open_seq;
    logic [7:0] status_word;

    function automatic logic cmd_valid(input logic [6:0] c);
        cmd_valid = (c == fcsf_pkg::CMD_ERASE_VERIFY) || (c == fcsf_pkg::CMD_PROGRAM) ||
                    (c == fcsf_pkg::CMD_BURST) || (c == fcsf_pkg::CMD_SECTOR_ERASE) ||
                    (c == fcsf_pkg::CMD_MASS_ERASE);
    endfunction

    // write-one request at one status position
    function automatic logic w1c(
        input logic wr,
        input logic [7:0] d,
        input int pos
    );
        w1c = wr && d[pos];
    endfunction

    // reserved positions stay zero; the caller masks the fail bit by mode
    function automatic logic [7:0] pack_status(
        input logic cbe,
        input logic cc,
        input logic pv,
        input logic ae,
        input logic blank,
        input logic fail
    );
        pack_status = 8'h00;
        pack_status[fcsf_pkg::BIT_CBE] = cbe;
        pack_status[fcsf_pkg::BIT_CC] = cc;
        pack_status[fcsf_pkg::BIT_PV] = pv;
        pack_status[fcsf_pkg::BIT_AE] = ae;
        pack_status[fcsf_pkg::BIT_BLANK] = blank;
        pack_status[fcsf_pkg::BIT_FAIL] = fail;
    endfunction

    assign st_wr = reg_wr && (reg_addr == fcsf_pkg::STATUS_OFFSET);
    assign st_one = w1c(st_wr, reg_wdata, fcsf_pkg::BIT_CBE);
    assign blocked = pv_q || ae_q;
    // launch needs a completed address and command stage
    assign do_launch = st_one && cbe_q && !blocked && (seq_q == SEQ_CMD);
    assign abort = st_wr && !reg_wdata[fcsf_pkg::BIT_CBE] && (seq_q != SEQ_IDLE);
    assign bad_cmd = cmd_wr && (seq_q == SEQ_ADDR) && !blocked && !cmd_valid(cmd_code);
    assign pv_set = array_wr && cbe_q && !blocked && (seq_q == SEQ_IDLE)
                    && array_wr_protected;
    assign ae_set = abort || bad_cmd || seq_violation || (stop_req && !cc_q);
    assign finish = active_q && engine_done;
    // burst chained after program keeps complete flag low
    assign chain = finish && pending_q;
    assign ev_done = finish && (active_cmd_q == fcsf_pkg::CMD_ERASE_VERIFY);
    // a protected address never opens a sequence
    assign open_seq = array_wr && cbe_q && array_wr_aligned && !pv_set;
    assign status_word = pack_status(cbe_q, cc_q, pv_q, ae_q, blank_q,
                                     fail_q && special_mode);

    // any error drops an open sequence so a later launch cannot slip through
    always_comb begin
        seq_d = seq_q;
        cmd_d = cmd_q;
        if (abort || do_launch || blocked) begin
            seq_d = SEQ_IDLE;
        end else begin
            case (seq_q)
                SEQ_IDLE: begin
                    if (open_seq) begin
                        seq_d = SEQ_ADDR;
                    end
                end
                SEQ_ADDR: begin
                    if (cmd_wr) begin
                        seq_d = cmd_valid(cmd_code) ? SEQ_CMD : SEQ_IDLE;
                        cmd_d = cmd_code;
                    end
                end
                SEQ_CMD: begin
                    seq_d = SEQ_CMD;
                end
                default: begin
                    seq_d = SEQ_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            seq_q <= SEQ_IDLE;
            cmd_q <= '0;
        end else if (clk_en) begin
            seq_q <= seq_d;
            cmd_q <= cmd_d;
        end
    end

    // one command runs while at most one more waits in the buffer
    always_comb begin
        pending_d = pending_q;
        active_d = active_q;
        active_cmd_d = active_cmd_q;
        if (do_launch && (!active_q || finish)) begin
            active_d = 1'b1;
            active_cmd_d = cmd_q;
        end else if (chain) begin
            pending_d = 1'b0;
            active_cmd_d = cmd_q;
        end else if (finish) begin
            active_d = 1'b0;
        end
        if (do_launch && active_q && !finish) begin
            pending_d = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pending_q <= 1'b0;
        end else if (clk_en) begin
            pending_q <= pending_d;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            active_q <= 1'b0;
            active_cmd_q <= '0;
        end else if (clk_en) begin
            active_q <= active_d;
            active_cmd_q <= active_cmd_d;
        end
    end

    // buffer empty: an idle engine takes the command at once, so it stays set
    always_comb begin
        cbe_d = cbe_q;
        if (do_launch && active_q && !finish) begin
            cbe_d = 1'b0;
        end else if (do_launch || chain) begin
            cbe_d = 1'b1;
        end
    end

    always_comb begin
        cc_d = cc_q;
        if (do_launch) begin
            cc_d = 1'b0;
        end else if (finish && !pending_q) begin
            cc_d = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cbe_q <= fcsf_pkg::STATUS_RESET[fcsf_pkg::BIT_CBE];
        end else if (clk_en) begin
            cbe_q <= cbe_d;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cc_q <= fcsf_pkg::STATUS_RESET[fcsf_pkg::BIT_CC];
        end else if (clk_en) begin
            cc_q <= cc_d;
        end
    end

    // error flags: a hardware set in the same cycle wins over a software clear
    always_comb begin
        pv_d = pv_q;
        if (pv_set) begin
            pv_d = 1'b1;
        end else if (w1c(st_wr, reg_wdata, fcsf_pkg::BIT_PV)) begin
            pv_d = 1'b0;
        end
    end

    always_comb begin
        ae_d = ae_q;
        if (ae_set) begin
            ae_d = 1'b1;
        end else if (w1c(st_wr, reg_wdata, fcsf_pkg::BIT_AE)) begin
            ae_d = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pv_q <= 1'b0;
        end else if (clk_en) begin
            pv_q <= pv_d;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ae_q <= 1'b0;
        end else if (clk_en) begin
            ae_q <= ae_d;
        end
    end

    always_comb begin
        blank_d = blank_q;
        if (ev_done) begin
            blank_d = verify_blank;
        end else if (do_launch) begin
            blank_d = 1'b0;
        end else if (special_mode && w1c(st_wr, reg_wdata, fcsf_pkg::BIT_BLANK)) begin
            blank_d = 1'b0;
        end
    end

    // fail clear works in either mode so a stale fail can always be removed
    always_comb begin
        fail_d = fail_q;
        if (special_mode && ev_done && !verify_blank) begin
            fail_d = 1'b1;
        end else if (w1c(st_wr, reg_wdata, fcsf_pkg::BIT_FAIL)) begin
            fail_d = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            blank_q <= 1'b0;
        end else if (clk_en) begin
            blank_q <= blank_d;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fail_q <= 1'b0;
        end else if (clk_en) begin
            fail_q <= fail_d;
        end
    end

    always_comb begin
        cfg_d = cfg_q;
        if (reg_wr && reg_addr == fcsf_pkg::CONFIG_OFFSET) begin
            cfg_d = reg_wdata & fcsf_pkg::CONFIG_MASK;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_q <= fcsf_pkg::CONFIG_RESET;
        end else if (clk_en) begin
            cfg_q <= cfg_d;
        end
    end

    always_comb begin
        rdata_d = 8'h00;
        if (reg_rd && reg_addr == fcsf_pkg::STATUS_OFFSET) begin
            rdata_d = status_word;
        end else if (reg_rd && reg_addr == fcsf_pkg::CONFIG_OFFSET) begin
            rdata_d = cfg_q;
        end
    end

    // registered: read data stand in the cycle after the strobe and hold while clk_en is low
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= '0;
        end else if (clk_en) begin
            reg_rdata <= rdata_d;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            launch <= 1'b0;
            launch_cmd <= '0;
        end else if (clk_en) begin
            launch <= do_launch;
            if (do_launch) begin
                launch_cmd <= cmd_q;
            end
        end
    end

    assign buffer_busy = !cbe_q;
    assign irq_buffer_empty = cbe_q && cfg_q[fcsf_pkg::BIT_CBE_IE];
    assign irq_complete = cc_q && cfg_q[fcsf_pkg::BIT_CC_IE];
endmodule
`default_nettype wire

// ---- fcsf_flags_chk.sv ----
// assertion checker for the flash status flag block
`default_nettype none
module fcsf_flags_chk (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic special_mode,
    input wire logic [8:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic engine_done,
    input wire logic launch,
    input wire logic buffer_busy,
    input wire logic irq_buffer_empty,
    input wire logic irq_complete
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_rsv; reg_rdata[3] == 1'b0 && reg_rdata[0] == 1'b0; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bit set");
    property p_fail; $past(reg_rd && !special_mode) |-> !reg_rdata[1]; endproperty
    a_fail: assert property (p_fail) else $error("fail bit in normal mode");
    property p_idle; $past(clk_en) && !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("read data outside read");
    property p_go; launch |-> $past(reg_wr && clk_en && reg_wdata[7]
        && reg_addr == fcsf_pkg::STATUS_OFFSET); endproperty
    a_go: assert property (p_go) else $error("launch without cause");
    property p_pulse; launch |=> !launch; endproperty
    a_pulse: assert property (p_pulse) else $error("launch too long");
    property p_be; irq_buffer_empty |-> !buffer_busy; endproperty
    a_be: assert property (p_be) else $error("empty irq while full");
    property p_ccl; launch |-> !irq_complete; endproperty
    a_ccl: assert property (p_ccl) else $error("complete irq at launch");
    property p_ccs; $rose(irq_complete) |-> $past(engine_done || reg_wr); endproperty
    a_ccs: assert property (p_ccs) else $error("complete irq without cause");
    property p_free; $fell(buffer_busy) |-> $past(engine_done); endproperty
    a_free: assert property (p_free) else $error("buffer freed early");
    c_go: cover property (launch);
    c_cc: cover property ($rose(irq_complete));
    c_free: cover property ($fell(buffer_busy));
endmodule
`default_nettype wire

// ---- fcsf_flags_test.sv ----
// self-checking bench for the flash status flag block
`default_nettype none
module fcsf_flags_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [8:0] ST = fcsf_pkg::STATUS_OFFSET;
    logic clk = 0, rst_b = 0, clk_en = 1, special_mode = 0, reg_wr = 0, reg_rd = 0;
    logic array_wr = 0, array_wr_aligned = 1, array_wr_protected = 0, cmd_wr = 0;
    logic seq_violation = 0, stop_req = 0, engine_done = 0, verify_blank = 0;
    logic [8:0] reg_addr = 9'h000;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    logic [6:0] cmd_code = 7'h00, launch_cmd;
    logic launch, buffer_busy, irq_buffer_empty, irq_complete;
    int n_mismatch = 0, checks_done = 0, cyc = 0;
    fcsf_flags uut (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .special_mode(special_mode),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .array_wr(array_wr), .array_wr_aligned(array_wr_aligned),
        .array_wr_protected(array_wr_protected), .cmd_wr(cmd_wr), .cmd_code(cmd_code),
        .seq_violation(seq_violation), .stop_req(stop_req), .engine_done(engine_done),
        .verify_blank(verify_blank), .launch(launch), .launch_cmd(launch_cmd),
        .buffer_busy(buffer_busy), .irq_buffer_empty(irq_buffer_empty),
        .irq_complete(irq_complete));
    initial forever #25 clk = ~clk;
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            close_out;
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [8:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    // address stage then command stage of a write sequence
    task automatic cmd(input logic prot, input logic [6:0] code);
        @(posedge clk);
        array_wr <= 1'b1;
        array_wr_protected <= prot;
        @(posedge clk);
        array_wr <= 1'b0;
        cmd_wr <= 1'b1;
        cmd_code <= code;
        @(posedge clk);
        cmd_wr <= 1'b0;
    endtask
    task automatic go(input logic exp);
        wr(ST, 8'h80);
        #1 chk(8'(launch), 8'(exp));
    endtask
    task automatic done(input logic blank);
        @(posedge clk);
        engine_done <= 1'b1;
        verify_blank <= blank;
        @(posedge clk);
        engine_done <= 1'b0;
    endtask
    task automatic t_normal;
        rd(ST, 8'hC0);
        wr(fcsf_pkg::CONFIG_OFFSET, 8'hC0);
        #1 chk(8'({irq_buffer_empty, irq_complete}), 8'h03);
        go(1'b0);
        cmd(1'b0, fcsf_pkg::CMD_ERASE_VERIFY);
        go(1'b1);
        chk(8'(launch_cmd), 8'h05);
        rd(ST, 8'h80);
        done(1'b1);
        rd(ST, 8'hC4);
        wr(ST, 8'h44);
        rd(ST, 8'hC4);
    endtask
    task automatic t_errors;
        cmd(1'b0, fcsf_pkg::CMD_PROGRAM);
        wr(ST, 8'h00);
        rd(ST, 8'hD4);
        cmd(1'b0, fcsf_pkg::CMD_PROGRAM);
        go(1'b0);
        wr(ST, 8'h10);
        wr(ST, 8'h00);
        rd(ST, 8'hC4);
        cmd(1'b0, 7'h7F);
        rd(ST, 8'hD4);
        wr(ST, 8'h10);
        cmd(1'b1, fcsf_pkg::CMD_SECTOR_ERASE);
        go(1'b0);
        wr(ST, 8'h00);
        rd(ST, 8'hE4);
        wr(ST, 8'h20);
        rd(ST, 8'hC4);
    endtask
    task automatic t_special;
        @(posedge clk);
        special_mode <= 1'b1;
        wr(ST, 8'h04);
        rd(ST, 8'hC0);
        cmd(1'b0, fcsf_pkg::CMD_ERASE_VERIFY);
        go(1'b1);
        done(1'b0);
        rd(ST, 8'hC2);
        wr(ST, 8'h02);
        rd(ST, 8'hC0);
        @(posedge clk);
        special_mode <= 1'b0;
    endtask
    task automatic t_misc;
        @(posedge clk);
        special_mode <= 1'b1;
        cmd(1'b0, fcsf_pkg::CMD_ERASE_VERIFY);
        go(1'b1);
        done(1'b0);
        @(posedge clk);
        special_mode <= 1'b0;
        rd(ST, 8'hC0);
        wr(ST, 8'h02);
        cmd(1'b0, fcsf_pkg::CMD_PROGRAM);
        go(1'b1);
        @(posedge clk);
        stop_req <= 1'b1;
        @(posedge clk);
        stop_req <= 1'b0;
        rd(ST, 8'h90);
        done(1'b0);
        wr(ST, 8'h10);
        @(posedge clk);
        stop_req <= 1'b1;
        @(posedge clk);
        stop_req <= 1'b0;
        rd(ST, 8'hC0);
        @(posedge clk);
        clk_en <= 1'b0;
        seq_violation <= 1'b1;
        @(posedge clk);
        clk_en <= 1'b1;
        seq_violation <= 1'b0;
        rd(ST, 8'hC0);
        @(posedge clk);
        seq_violation <= 1'b1;
        @(posedge clk);
        seq_violation <= 1'b0;
        rd(ST, 8'hD0);
        wr(ST, 8'h10);
        rd(ST, 8'hC0);
    endtask
    task automatic t_burst;
        cmd(1'b0, fcsf_pkg::CMD_PROGRAM);
        go(1'b1);
        cmd(1'b0, fcsf_pkg::CMD_BURST);
        wr(ST, 8'h80);
        #1 chk(8'(buffer_busy), 8'h01);
        done(1'b0);
        rd(ST, 8'h80);
        done(1'b0);
        rd(ST, 8'hC0);
        chk(8'(irq_complete), 8'h01);
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        t_normal;
        t_errors;
        t_special;
        t_burst;
        t_misc;
        close_out;
    end
endmodule
bind fcsf_flags fcsf_flags_chk chk (.clk(clk), .rst_b(rst_b), .clk_en(clk_en),
    .special_mode(special_mode), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .engine_done(engine_done),
    .launch(launch), .buffer_busy(buffer_busy), .irq_buffer_empty(irq_buffer_empty),
    .irq_complete(irq_complete));
`default_nettype wire
